// ==== core/burst_order.v ====
// Column sequencer for one burst inside its aligned block
`timescale 1ns/100ps
`include "ddr_cmd_regs.vh"
module burst_order (
    input wire [12:0] start_col,
    input wire [2:0] beat,
    input wire [2:0] len_code,
    input wire interleaved,
    output reg [12:0] col
);
    reg [2:0] mask;
    reg [2:0] low;
    always @* begin
        case (len_code)
            `BL2_CODE: mask = 3'h1;
            `BL4_CODE: mask = 3'h3;
            `BL8_CODE: mask = 3'h7;
            default: mask = 3'h1;
        endcase
        if (interleaved)
            low = start_col[2:0] ^ beat;
        else
            low = start_col[2:0] + beat;
        col = {start_col[12:3], (start_col[2:0] & ~mask) | (low & mask)};
    end
endmodule // burst_order

// ==== core/ddr_cmd_mode_decode.v ====
// Command decoder, mode and extended settings, burst column sequencing
// Function
// - Length two: bit zero picks start, order 0-1 or 1-0.
// - Length four: bits zero-one start; sequential 1-2-3-0, interleaved 1-0-3-2.
// - Length eight: bits zero-two start; start five gives listed orders.
// - Sequential adds beat modulo length; interleaved XORs; never leaves block.
// - Read latency programmable to 2 or 2.5 clocks from read command.
// - Mode load with bits seven-twelve zero selects normal operation.
// - Mode load with only bit eight set among high bits resets loop.
// - Load with bank bit zero high and bank bit one low writes the extended register.
// - Extended register holds contents until rewritten.
// - Extended bit zero: 0 enables loop, 1 disables it.
// - Extended bit one: 0 normal drive, 1 reduced drive.
// - After loop enable, 200 clocks before read accepted; self refresh exit enables.
// - Decode select, row, column and write strobes into commands.
// - Refresh code is auto refresh with clock enable high, else self refresh.
// - Mode fields: length, type, latency, operating mode at given bits.
// - Load with both bank bits low writes mode register; bit eight self-clears.
`timescale 1ns/100ps
`include "ddr_cmd_regs.vh"
module ddr_cmd_mode_decode (
    input wire sys_clk,
    input wire rst_b,
    input wire cs_b,
    input wire ras_b,
    input wire cas_b,
    input wire we_b,
    input wire cke,
    input wire bank_sel_0,
    input wire bank_sel_1,
    input wire [12:0] addr,
    output reg [3:0] cmd_q,
    output reg cmd_valid_q,
    output reg [12:0] mode_q,
    output reg [12:0] extended_settings_q,
    output reg dll_enabled_q,
    output reg dll_reset_q,
    output reg dll_ready_q,
    output reg drive_strength_bit_q,
    output reg self_refresh_q,
    output reg ext_reserved_q,
    output reg mode_reserved_q,
    output reg read_refused_q,
    output reg [2:0] read_latency_setting_q,
    output reg burst_active_q,
    output reg [12:0] burst_col_q,
    output reg [1:0] burst_bank_q,
    output reg burst_is_write_q,
    output reg data_valid_q,
    output reg data_half_q
);
    // Two-stage synchronisers on all pins; reset shows a deselected idle bus
    wire [19:0] pin_raw = {cs_b, ras_b, cas_b, we_b, cke, bank_sel_1, bank_sel_0, addr};
    wire [19:0] pin_init = `PIN_RESET;
    wire [19:0] pin_sync;
    genvar g;
    generate
        for (g = 0; g < `PIN_W; g = g + 1) begin : g_sync
            reg s1_q;
            reg s2_q;
            always @(posedge sys_clk) begin
                if (!rst_b) begin
                    s1_q <= pin_init[g];
                    s2_q <= pin_init[g];
                end else begin
                    s1_q <= pin_raw[g];
                    s2_q <= s1_q;
                end
            end
            // Only the second stage is read
            assign pin_sync[g] = s2_q;
        end
    endgenerate
    wire s_cs_b = pin_sync[19];
    wire s_ras_b = pin_sync[18];
    wire s_cas_b = pin_sync[17];
    wire s_we_b = pin_sync[16];
    wire s_cke = pin_sync[15];
    wire [1:0] s_bank = pin_sync[14:13];
    wire [12:0] s_addr = pin_sync[12:0];

    reg [3:0] cmd_d;
    always @* begin
        if (s_cs_b)
            cmd_d = `CMD_DESEL;
        else begin
            case ({s_ras_b, s_cas_b, s_we_b})
                3'h7: cmd_d = `CMD_NOP;
                3'h3: cmd_d = `CMD_ACT;
                3'h5: cmd_d = `CMD_RD;
                3'h4: cmd_d = `CMD_WR;
                3'h6: cmd_d = `CMD_BST;
                3'h2: cmd_d = `CMD_PRE;
                3'h1: cmd_d = s_cke ? `CMD_AREF : `CMD_SREF;
                3'h0: cmd_d = `CMD_LMR;
                default: cmd_d = `CMD_NOP;
            endcase
        end
    end

    wire is_lmr = (cmd_d == `CMD_LMR);
    wire mode_wr = is_lmr && (s_bank == `BANK_MODE);
    wire ext_wr = is_lmr && (s_bank == `BANK_EXT);
    wire [5:0] op_field = s_addr[`MODE_OP_MSB:`MODE_OP_LSB];
    wire op_ok = (op_field == `OP_NORMAL) || (op_field == `OP_DLL_RESET);
    wire [2:0] lat_field = s_addr[`MODE_LAT_MSB:`MODE_LAT_LSB];
    wire lat_ok = (lat_field == `LAT2_CODE) || (lat_field == `LAT25_CODE);
    wire dll_turn_on = ext_wr && !s_addr[`EXT_DLL_BIT] && !dll_enabled_q;
    wire sref_exit = self_refresh_q && s_cke;
    wire read_cmd = (cmd_d == `CMD_RD);
    wire write_cmd = (cmd_d == `CMD_WR);
    wire read_ok = read_cmd && dll_ready_q;

    // Loop lock counter
    reg [7:0] lock_cnt_q;
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            lock_cnt_q <= 8'h00;
            dll_ready_q <= 1'b0;
        end else if (dll_turn_on || sref_exit || (mode_wr && op_field == `OP_DLL_RESET)) begin
            lock_cnt_q <= 8'h00;
            dll_ready_q <= 1'b0;
        end else if (!dll_enabled_q) begin
            dll_ready_q <= 1'b0;
        end else if (lock_cnt_q != `DLL_LOCK_CYCLES) begin
            lock_cnt_q <= lock_cnt_q + 8'h01;
            dll_ready_q <= (lock_cnt_q == `DLL_LOCK_CYCLES - 8'h01);
        end
    end

    // Command register and per-cycle flags
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            cmd_q <= `CMD_DESEL;
            cmd_valid_q <= 1'b0;
            read_refused_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            cmd_valid_q <= (cmd_d != `CMD_DESEL) && (cmd_d != `CMD_NOP);
            read_refused_q <= read_cmd && !dll_ready_q;
        end
    end

    // Base mode register
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            mode_q <= `MODE_RESET;
            mode_reserved_q <= 1'b0;
            dll_reset_q <= 1'b0;
            read_latency_setting_q <= `LAT25_CODE;
        end else begin
            dll_reset_q <= 1'b0;
            if (mode_wr) begin
                // Loop-reset bit is not retained
                mode_q <= s_addr & ~(13'h0001 << `MODE_DLLRST_BIT);
                mode_reserved_q <= !op_ok || !lat_ok;
                dll_reset_q <= (op_field == `OP_DLL_RESET);
                if (lat_ok)
                    read_latency_setting_q <= lat_field;
            end
        end
    end

    // Extended register and self refresh state
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            extended_settings_q <= `EXT_RESET;
            dll_enabled_q <= 1'b0;
            drive_strength_bit_q <= 1'b0;
            self_refresh_q <= 1'b0;
            ext_reserved_q <= 1'b0;
        end else begin
            if (ext_wr) begin
                extended_settings_q <= s_addr;
                dll_enabled_q <= !s_addr[`EXT_DLL_BIT];
                drive_strength_bit_q <= s_addr[`EXT_DRIVE_BIT];
                ext_reserved_q <= s_addr[`EXT_FET_BIT]
                    || (s_addr[`EXT_RSV_MSB:`EXT_RSV_LSB] != 10'h000);
            end
            if (cmd_d == `CMD_SREF)
                self_refresh_q <= 1'b1;
            else if (sref_exit) begin
                self_refresh_q <= 1'b0;
                dll_enabled_q <= 1'b1;
            end
        end
    end

    // Burst sequencing
    reg [12:0] start_q;
    reg [2:0] beat_q;
    reg [2:0] beats_left_q;
    reg [1:0] lat_cnt_q;
    reg lat_half_q;
    // Sequencer states: idle, latency wait, data beats
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_BEAT = 2'h2;
    reg [1:0] state_q;
    wire [12:0] col_w;
    burst_order u_order (
        .start_col(start_q),
        .beat(beat_q),
        .len_code(mode_q[`MODE_BL_MSB:`MODE_BL_LSB]),
        .interleaved(mode_q[`MODE_BT_BIT]),
        .col(col_w)
    );
    reg [2:0] len_m1;
    always @* begin
        case (mode_q[`MODE_BL_MSB:`MODE_BL_LSB])
            `BL2_CODE: len_m1 = 3'h1;
            `BL4_CODE: len_m1 = 3'h3;
            `BL8_CODE: len_m1 = 3'h7;
            default: len_m1 = 3'h1;
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            start_q <= 13'h0000;
            beat_q <= 3'h0;
            beats_left_q <= 3'h0;
            lat_cnt_q <= 2'h0;
            lat_half_q <= 1'b0;
            state_q <= ST_IDLE;
            burst_active_q <= 1'b0;
            burst_col_q <= 13'h0000;
            burst_bank_q <= 2'h0;
            burst_is_write_q <= 1'b0;
            data_valid_q <= 1'b0;
            data_half_q <= 1'b0;
        end else if (read_ok || write_cmd) begin
            start_q <= s_addr;
            beat_q <= 3'h0;
            beats_left_q <= len_m1;
            burst_bank_q <= s_bank;
            burst_is_write_q <= write_cmd;
            burst_active_q <= 1'b1;
            data_valid_q <= 1'b0;
            // Reads wait out the latency, writes take data on the next clock
            state_q <= read_ok ? ST_WAIT : ST_BEAT;
            // Registration edge and the wait edge make the two full clocks
            lat_cnt_q <= `FULL_LAT_CYCLES - 2'h2;
            lat_half_q <= (read_latency_setting_q == `LAT25_CODE);
        end else if (cmd_d == `CMD_BST && !burst_is_write_q) begin
            state_q <= ST_IDLE;
            burst_active_q <= 1'b0;
            data_valid_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    data_valid_q <= 1'b0;
                end
                ST_WAIT: begin
                    data_valid_q <= 1'b0;
                    if (lat_cnt_q != 2'h0)
                        lat_cnt_q <= lat_cnt_q - 2'h1;
                    else
                        state_q <= ST_BEAT;
                end
                ST_BEAT: begin
                    burst_col_q <= col_w;
                    data_valid_q <= 1'b1;
                    data_half_q <= lat_half_q;
                    beat_q <= beat_q + 3'h1;
                    if (beats_left_q == 3'h0) begin
                        state_q <= ST_IDLE;
                        burst_active_q <= 1'b0;
                    end else begin
                        beats_left_q <= beats_left_q - 3'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    burst_active_q <= 1'b0;
                    data_valid_q <= 1'b0;
                end
            endcase
        end
    end
endmodule // ddr_cmd_mode_decode

// ==== core/ddr_cmd_regs.vh ====
// Constants for the command decoder, mode settings and burst ordering
`ifndef DDR_CMD_REGS_VH
`define DDR_CMD_REGS_VH
`define ADDR_W 13
`define PIN_W 20
`define PIN_RESET 20'hf8000
`define MODE_BL_LSB 0
`define MODE_BL_MSB 2
`define MODE_BT_BIT 3
`define MODE_LAT_LSB 4
`define MODE_LAT_MSB 6
`define MODE_OP_LSB 7
`define MODE_OP_MSB 12
`define MODE_DLLRST_BIT 8
`define MODE_RESET 13'h0000
`define EXT_RESET 13'h0000
`define EXT_DLL_BIT 0
`define EXT_DRIVE_BIT 1
`define EXT_FET_BIT 2
`define EXT_RSV_LSB 3
`define EXT_RSV_MSB 12
`define BL2_CODE 3'h1
`define BL4_CODE 3'h2
`define BL8_CODE 3'h3
`define LAT2_CODE 3'h2
`define LAT25_CODE 3'h6
`define OP_NORMAL 6'h00
`define OP_DLL_RESET 6'h02
`define BANK_MODE 2'h0
`define BANK_EXT 2'h1
`define CMD_NOP 4'h0
`define CMD_ACT 4'h1
`define CMD_RD 4'h2
`define CMD_WR 4'h3
`define CMD_BST 4'h4
`define CMD_PRE 4'h5
`define CMD_AREF 4'h6
`define CMD_SREF 4'h7
`define CMD_LMR 4'h8
`define CMD_DESEL 4'h9
`define DLL_LOCK_CYCLES 8'hc8
`define HALF_LAT_CYCLES 2'h2
`define FULL_LAT_CYCLES 2'h2
`endif

// ==== tb/cmd_decode_properties.sv ====
// Checker for command decode, settings and burst sequencing
`timescale 1ns/100ps
`include "ddr_cmd_regs.vh"
module cmd_decode_properties (
    input wire sys_clk,
    input wire rst_b,
    input wire cs_b,
    input wire ras_b,
    input wire cas_b,
    input wire we_b,
    input wire bank_sel_0,
    input wire bank_sel_1,
    input wire [12:0] addr,
    input wire [3:0] cmd_q,
    input wire [12:0] mode_q,
    input wire [12:0] extended_settings_q,
    input wire dll_enabled_q,
    input wire dll_reset_q,
    input wire dll_ready_q,
    input wire drive_strength_bit_q,
    input wire ext_reserved_q,
    input wire [2:0] read_latency_setting_q,
    input wire [12:0] burst_col_q,
    input wire data_valid_q,
    input wire data_half_q
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!rst_b);
// Pins pass a two-stage synchroniser, so decode is judged only once it is flushed
reg [2:0] up_q;
always @(posedge sys_clk) begin
    up_q <= !rst_b ? 3'h0 : (up_q == 3'h4 ? up_q : up_q + 3'h1);
end
desel_decode_a: assert property (
    up_q == 3'h4 && $past(cs_b, 3) |-> cmd_q == `CMD_DESEL) else $error("deselect missed");
read_decode_a: assert property (
    up_q == 3'h4 && $past({cs_b, ras_b, cas_b, we_b}, 3) == 4'h5 |-> cmd_q == `CMD_RD)
    else $error("read missed");
lock_wait_a: assert property (
    $rose(dll_enabled_q) || dll_reset_q |=> !dll_ready_q [*8]) else $error("early ready");
reset_clear_a: assert property (
    !mode_q[`MODE_DLLRST_BIT]) else $error("loop reset bit kept");
drive_bit_a: assert property (
    drive_strength_bit_q == extended_settings_q[`EXT_DRIVE_BIT]) else $error("drive wrong");
ext_load_a: assert property (
    up_q == 3'h4 && $past({cs_b, ras_b, cas_b, we_b, bank_sel_1, bank_sel_0}, 3) == 6'h01
    |-> extended_settings_q == $past(addr, 3)) else $error("extended load missed");
mode_load_a: assert property (
    up_q == 3'h4 && $past({cs_b, ras_b, cas_b, we_b, bank_sel_1, bank_sel_0}, 3) == 6'h00
    |-> mode_q == ($past(addr, 3) & 13'h1eff)) else $error("mode load missed");
block_hold_a: assert property (
    data_valid_q && $past(data_valid_q) |-> burst_col_q[12:3] == $past(burst_col_q[12:3]))
    else $error("burst left block");
half_flag_a: assert property (
    data_valid_q |-> data_half_q == (read_latency_setting_q == `LAT25_CODE))
    else $error("half flag wrong");
ext_reserved_a: assert property (
    $rose(ext_reserved_q) |-> |extended_settings_q[12:2]) else $error("reserved flag wrong");
cover property ($rose(dll_ready_q));
cover property (data_valid_q && data_half_q);
cover property ($rose(ext_reserved_q));
endmodule // cmd_decode_properties
bind ddr_cmd_mode_decode cmd_decode_properties i_cmd_decode_properties (
    .sys_clk(sys_clk), .rst_b(rst_b), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b),
    .we_b(we_b), .bank_sel_0(bank_sel_0), .bank_sel_1(bank_sel_1), .addr(addr),
    .cmd_q(cmd_q), .mode_q(mode_q), .extended_settings_q(extended_settings_q),
    .dll_enabled_q(dll_enabled_q), .dll_reset_q(dll_reset_q), .dll_ready_q(dll_ready_q),
    .drive_strength_bit_q(drive_strength_bit_q), .ext_reserved_q(ext_reserved_q),
    .read_latency_setting_q(read_latency_setting_q), .burst_col_q(burst_col_q),
    .data_valid_q(data_valid_q), .data_half_q(data_half_q));

// ==== tb/ctrl_model.sv ====
// Memory controller model driving the command pins
`timescale 1ns/100ps
module ctrl_model (
    input wire sys_clk,
    output reg cs_b,
    output reg ras_b,
    output reg cas_b,
    output reg we_b,
    output reg cke,
    output reg bank_sel_0,
    output reg bank_sel_1,
    output reg [12:0] addr
);
initial begin
    {cs_b, ras_b, cas_b, we_b} = 4'hf;
    cke = 1'b1;
    {bank_sel_1, bank_sel_0} = 2'h0;
    addr = 13'h0000;
end
task issue(input [3:0] pins, input [1:0] bank, input [12:0] a, input c);
    begin
        {cs_b, ras_b, cas_b, we_b} = pins;
        {bank_sel_1, bank_sel_0} = bank;
        addr = a;
        cke = c;
        @(posedge sys_clk);
        #1;
        // Deselected lines carry the inverse so a stale value cannot match
        {cs_b, ras_b, cas_b, we_b} = {1'b1, ~pins[2:0]};
        {bank_sel_1, bank_sel_0} = ~bank;
        addr = ~a;
    end
endtask
endmodule // ctrl_model

// ==== tb/ddr_sdram_cmd_mode_decode_tb.sv ====
// Self-checking bench for the command decoder and burst sequencing
`timescale 1ns/100ps
`include "ddr_cmd_regs.vh"
module ddr_sdram_cmd_mode_decode_tb;
reg sys_clk = 1'b0;
reg rst_b = 1'b0;
wire cs_b, ras_b, cas_b, we_b, cke, bank_sel_0, bank_sel_1;
wire [12:0] addr, mode_q, ext_q, col_q;
wire [3:0] cmd_q;
wire [2:0] lat_q;
wire [1:0] bank_q;
wire vld, en, rst, rdy, ds, sref, ersv, mrsv, refused, act, wr, dv, half;
integer seed = 60;
integer bad_count = 0;
integer n_compared = 0;
integer i, j, st, fdv;
time t_en;
reg [12:0] exp_q [$];
reg s_cmd, s_rst, s_ref, s_vld;
ctrl_model i_ctrl_model (.sys_clk(sys_clk), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b),
    .we_b(we_b), .cke(cke), .bank_sel_0(bank_sel_0), .bank_sel_1(bank_sel_1), .addr(addr));
ddr_cmd_mode_decode i_ddr_cmd_mode_decode (.sys_clk(sys_clk), .rst_b(rst_b), .cs_b(cs_b),
    .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .cke(cke), .bank_sel_0(bank_sel_0),
    .bank_sel_1(bank_sel_1), .addr(addr), .cmd_q(cmd_q), .cmd_valid_q(vld), .mode_q(mode_q),
    .extended_settings_q(ext_q), .dll_enabled_q(en), .dll_reset_q(rst), .dll_ready_q(rdy),
    .drive_strength_bit_q(ds), .self_refresh_q(sref), .ext_reserved_q(ersv),
    .mode_reserved_q(mrsv), .read_refused_q(refused), .read_latency_setting_q(lat_q),
    .burst_active_q(act), .burst_col_q(col_q), .burst_bank_q(bank_q),
    .burst_is_write_q(wr), .data_valid_q(dv), .data_half_q(half));
initial begin
    forever #50 sys_clk = ~sys_clk;
end
task check(input [12:0] seen, input [12:0] exp);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    end
endtask
task complete_run;
    begin
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    end
endtask
// Watches pulses and compares every beat with the queued column order
task watch(input integer cyc, input [3:0] ec);
    for (j = 0; j < cyc; j = j + 1) begin
        @(posedge sys_clk);
        #1;
        s_cmd = s_cmd | (cmd_q === ec);
        s_rst = s_rst | (rst === 1'b1);
        s_ref = s_ref | (refused === 1'b1);
        s_vld = s_vld | (vld === 1'b1);
        if (dv === 1'b1) begin
            if (fdv < 0)
                fdv = j;
            check(col_q, exp_q.size() ? exp_q.pop_front() : {13{1'bx}});
        end
    end
endtask
task op(input [3:0] p, input [1:0] b, input [12:0] a, input c, input [3:0] ec, input integer n);
    begin
        s_cmd = 1'b0;
        s_rst = 1'b0;
        s_ref = 1'b0;
        s_vld = 1'b0;
        fdv = -1;
        i_ctrl_model.issue(p, b, a, c);
        watch(n, ec);
        check(s_cmd, 1'b1);
    end
endtask
task burst(input [2:0] blc, input bt, input w, input [12:0] s);
    integer n, k;
    reg [1:0] bk;
    begin
        n = 2 << (blc - 1);
        for (k = 0; k < n; k = k + 1) begin
            exp_q.push_back(13'((s & ~(n - 1)) | ((bt ? (s ^ k) : (s + k)) & (n - 1))));
        end
        bk = 2'($random(seed));
        op(w ? 4'h4 : 4'h5, bk, s, 1'b1, w ? `CMD_WR : `CMD_RD, 14);
        check(exp_q.size(), 13'h0);
        check(fdv, w ? 13'h2 : 13'h3);
        check(bank_q, bk);
        check(wr, w);
        check(act, 1'b0);
    end
endtask
initial begin
    #(5000000);
    bad_count = bad_count + 1;
    complete_run;
end
initial begin
    repeat (3) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    watch(3, 4'h0);
    check(mode_q, `MODE_RESET);
    check(ext_q, `EXT_RESET);
    check(lat_q, `LAT25_CODE);
    $display("test reset values done");
    op(4'h0, `BANK_EXT, 13'h0002, 1'b1, `CMD_LMR, 5);
    check(ext_q, 13'h0002);
    check(ds, 1'b1);
    check(en, 1'b1);
    op(4'h5, 2'h0, 13'h0000, 1'b1, `CMD_RD, 8);
    check(s_ref, 1'b1);
    t_en = $time;
    op(4'h0, `BANK_MODE, 13'h0123, 1'b1, `CMD_LMR, 5);
    check(s_rst, 1'b1);
    check(mode_q, 13'h0023);
    for (i = 0; i < 400 && rdy !== 1'b1; i = i + 1) watch(1, 4'h0);
    check(rdy, 1'b1);
    check((($time - t_en) >= 20000) && (($time - t_en) <= 20400), 1'b1);
    $display("test loop lock done");
    // Latency two is allowed at this clock rate; codes kept legal
    for (i = 0; i < 12; i = i + 1) begin
        op(4'h0, `BANK_MODE, {6'h00, i[0] ? 3'h6 : 3'h2, i[1], 3'(i / 4 + 1)}, 1'b1,
            `CMD_LMR, 5);
        check(mode_q, {6'h00, i[0] ? 3'h6 : 3'h2, i[1], 3'(i / 4 + 1)});
        check(lat_q, i[0] ? `LAT25_CODE : `LAT2_CODE);
        burst(3'(i / 4 + 1), i[1], 1'b0, 13'($random(seed)));
        burst(3'(i / 4 + 1), i[1], 1'b1, 13'(i == 11 ? 5 : $random(seed)));
        check(half, i[0]);
    end
    $display("test burst orders done");
    op(4'h0, `BANK_MODE, 13'h0033, 1'b1, `CMD_LMR, 5);
    check(lat_q, `LAT25_CODE);
    check(mrsv, 1'b1);
    op(4'h0, `BANK_EXT, 13'h0004, 1'b1, `CMD_LMR, 5);
    check(ersv, 1'b1);
    op(4'h0, `BANK_EXT, 13'h0001, 1'b1, `CMD_LMR, 5);
    check(en, 1'b0);
    check(ersv, 1'b0);
    $display("test reserved codes done");
    op(4'h1, 2'h0, 13'h0000, 1'b0, `CMD_SREF, 5);
    check(sref, 1'b1);
    op(4'h7, 2'h0, 13'h0000, 1'b1, `CMD_NOP, 5);
    check(sref, 1'b0);
    check(en, 1'b1);
    for (i = 0; i < 6; i = i + 1) begin
        op(24'h372618 >> (4 * i), 2'h0, 13'h0000, 1'b1, 24'h105469 >> (4 * i), 5);
        check(s_vld, i != 0 && i != 4);
    end
    $display("test command table done");
    complete_run;
end
endmodule // ddr_sdram_cmd_mode_decode_tb
